// *** smsar_sequencer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "smsar_defines.vh"
// Contract
// - Encode/decode select low during sign trial; comparator is polarity detector.
// - Encode/decode select high for all magnitude trials after polarity known.
// - Positive input: comparator stored unchanged as magnitude decision.
// - Negative input: comparator inverted by sign-controlled XOR before storing.
// - Inversion passes comparator uninverted during sign decision.
// - Magnitude all ones at full scale, all zeros at zero scale.
// - Conventional register starts at 01111111, clearing bits one by one.
// - This register loads 10111111 at conversion start.
// - Timing shifter holds all ones after eight clocks with start inactive.
// - Start high shifts a one into the timing shifter every clock.
// - All ones and start low: next clock shifts zero into sign stage.
// - Zero walks one stage per clock to last magnitude stage, ones behind.
// - Start accepted at any time, unsynchronised to clock; code synchronises it and acts only when the shifter holds all ones.
// - Conversion-complete output stays high 8 clocks per conversion.
// - Sign strobe holds decode mode; its rising edge releases to encode.
// - Sign strobe rising edge captures comparator as sign bit.
// - Each magnitude trial clears its bit; strobe end captures decision, MSB first.
module smsar_sequencer
(
  input wire clock,
  input wire nrst,
  input wire startN,
  input wire compOut,
  output reg encodeSelect,
  output reg [7:0] trialStrobeN,
  output reg signStageOutput,
  output reg lastMagnitudeStageOutput,
  output reg signBitControl,
  output reg [7:0] code,
  output reg convComplete,
  output reg codeValid
);
  // ----------------------------------------
  // Start input crossing
  // ----------------------------------------
  wire startSync;
  smsar_sync startSyncInst
  (
    .clock(clock),
    .nrst(nrst),
    .din(startN),
    .dout(startSync),
    .stable()
  );

  // ----------------------------------------
  // Timing shift register
  // ----------------------------------------
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg [7:0] code_q;
  reg [7:0] code_d;
  reg sign_q;
  reg sign_d;
  reg [3:0] doneCnt_q;
  reg [3:0] doneCnt_d;
  wire allOnes;
  wire decision;
  integer i;

  assign allOnes = (shift_q == `SMSAR_ALL_ONES);
  // Sign is held zero until captured, so XOR passes straight during sign trial
  assign decision = compOut ^ sign_q;

  always @*
  begin
    // Ones shift in unless start low with all stages idle
    shift_d = {shift_q[6:0], ~(allOnes & ~startSync)};
    code_d = code_q;
    sign_d = sign_q;
    doneCnt_d = doneCnt_q;
    if (allOnes && !startSync)
    begin
      code_d = `SMSAR_INIT_CODE;
      sign_d = 1'b0;
      doneCnt_d = `SMSAR_DONE_CYCLES;
    end
    else
    begin
      if (doneCnt_q != 4'h0)
      begin
        doneCnt_d = doneCnt_q - 4'h1;
      end
      // Sign strobe ends: latch polarity, inversion control is high for negative
      if (!shift_q[0])
      begin
        sign_d = ~compOut;
        code_d[`SMSAR_SIGN_POS] = compOut;
      end
      for (i = 1; i < `SMSAR_STAGES; i = i + 1)
      begin
        // Trial start clears its bit
        if (!shift_q[i - 1])
        begin
          code_d[`SMSAR_SIGN_POS - i] = 1'b0;
        end
      end
      for (i = 1; i < `SMSAR_STAGES; i = i + 1)
      begin
        // Trial end stores the decision
        if (!shift_q[i])
        begin
          code_d[`SMSAR_SIGN_POS - i] = decision;
        end
      end
    end
  end

  // ----------------------------------------
  // State and registered outputs
  // ----------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_q <= `SMSAR_ALL_ONES;
      code_q <= 8'h00;
      sign_q <= 1'b0;
      doneCnt_q <= 4'h0;
      encodeSelect <= 1'b1;
      trialStrobeN <= `SMSAR_ALL_ONES;
      signStageOutput <= 1'b1;
      lastMagnitudeStageOutput <= 1'b1;
      signBitControl <= 1'b0;
      code <= 8'h00;
      convComplete <= 1'b0;
      codeValid <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      code_q <= code_d;
      sign_q <= sign_d;
      doneCnt_q <= doneCnt_d;
      encodeSelect <= shift_d[0];
      trialStrobeN <= shift_d;
      signStageOutput <= shift_d[0];
      lastMagnitudeStageOutput <= shift_d[`SMSAR_LAST_STAGE];
      signBitControl <= sign_d;
      code <= code_d;
      convComplete <= (doneCnt_d != 4'h0);
      codeValid <= shift_d[`SMSAR_LAST_STAGE] & ~shift_q[`SMSAR_LAST_STAGE];
    end
  end
endmodule // smsar_sequencer
`default_nettype wire

// *** smsar_defines.vh ***
`ifndef SMSAR_DEFINES_VH
`define SMSAR_DEFINES_VH
// ----------------------------------------
// Widths and codes
// ----------------------------------------
`define SMSAR_STAGES 8
`define SMSAR_CODE_W 8
`define SMSAR_ALL_ONES 8'hFF
`define SMSAR_INIT_CODE 8'hBF
`define SMSAR_CONV_CODE 8'h7F
`define SMSAR_SIGN_POS 7
`define SMSAR_LAST_STAGE 7
`define SMSAR_DONE_CYCLES 4'h8
`define SMSAR_CNT_W 4
`endif

// *** smsar_sync.v ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Three-stage input synchroniser
// ----------------------------------------
module smsar_sync
(
  input wire clock,
  input wire nrst,
  input wire din,
  output wire dout,
  output wire stable
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg out_q;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      out_q <= 1'b1;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        out_q <= s2_q;
      end
    end
  end
  assign dout = out_q;
  assign stable = (s2_q == s3_q);
endmodule // smsar_sync
`default_nettype wire

// *** smsar_dac_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module smsar_dac_model
(
  input wire logic encodeSelect,
  input wire logic [7:0] code,
  input wire logic posIn,
  input wire logic [6:0] mag,
  output logic compOut
);
  // Decode mode tests polarity only; encode compares magnitude, flipped below zero
  assign compOut = encodeSelect ? ((mag > code[6:0]) ^ !posIn) : posIn;
endmodule // smsar_dac_model
`default_nettype wire

// *** smsar_sequencer_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module smsar_sequencer_checker
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic encodeSelect,
  input wire logic [7:0] trialStrobeN,
  input wire logic signBitControl,
  input wire logic [7:0] code,
  input wire logic convComplete
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_MODE: assert property (encodeSelect == trialStrobeN[0])
    else $error("select bad");
  AST_ONE: assert property ($onehot0(~trialStrobeN))
    else $error("strobes bad");
  AST_WALK: assert property (trialStrobeN[7] && !(&trialStrobeN) |=>
    trialStrobeN == {$past(trialStrobeN[6:0]), 1'b1}) else $error("walk bad");
  AST_TAIL: assert property (!trialStrobeN[7] |=> &trialStrobeN)
    else $error("tail bad");
  AST_SIGN: assert property (!trialStrobeN[0] |-> !signBitControl)
    else $error("sign bad");
  AST_LOAD: assert property ($fell(trialStrobeN[0]) |-> code == 8'hBF)
    else $error("load bad");
  AST_HOLD: assert property (&trialStrobeN && $past(trialStrobeN) == 8'hFF |-> $stable(code))
    else $error("hold bad");
  AST_DONE: assert property ($fell(trialStrobeN[0]) |-> convComplete[*8] ##1 !convComplete)
    else $error("done bad");
  cover property ($fell(trialStrobeN[0]));
  cover property ($rose(trialStrobeN[7]) && code == 8'hFF);
  cover property ($rose(trialStrobeN[7]) && code == 8'h00);
endmodule // smsar_sequencer_checker
bind smsar_sequencer smsar_sequencer_checker chk (.clock(clock), .nrst(nrst),
  .encodeSelect(encodeSelect), .trialStrobeN(trialStrobeN),
  .signBitControl(signBitControl), .code(code), .convComplete(convComplete));
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic startN = 1'b1;
  logic posIn = 1'b1;
  logic [6:0] mag = 7'h00;
  logic compOut, encodeSelect, sso, lmso, signBitControl, convComplete, codeValid;
  logic [7:0] trialStrobeN, code;
  int fail_count = 0;
  int checked = 0;
  // Row: sign input, magnitude input, expected code
  logic [15:0] rows [6] = '{16'hFFFF, 16'h7F7F, 16'h8080, 16'h0000, 16'hD5D5, 16'h2A2A};
  smsar_sequencer uut (.clock(clock), .nrst(nrst), .startN(startN), .compOut(compOut),
    .encodeSelect(encodeSelect), .trialStrobeN(trialStrobeN), .signStageOutput(sso),
    .lastMagnitudeStageOutput(lmso), .signBitControl(signBitControl), .code(code),
    .convComplete(convComplete), .codeValid(codeValid));
  smsar_dac_model dac (.encodeSelect(encodeSelect), .code(code), .posIn(posIn),
    .mag(mag), .compOut(compOut));
  initial forever #4 clock = ~clock;
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task conv(input logic [15:0] r, input int hold);
    int n;
    @(posedge clock);
    posIn <= r[15];
    mag <= r[14:8];
    startN <= 1'b0;
    repeat (hold) @(posedge clock);
    startN <= 1'b1;
    n = 0;
    while (codeValid !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 40)
    begin
      fail_count++;
      results();
    end
    chk("code", r[7:0], code);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk("strobes", 8'hFF, trialStrobeN);
    repeat (4) @(posedge clock);
    foreach (rows[i]) conv(rows[i], 2);
    @(posedge clock);
    startN <= 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b0;
    startN <= 1'b1;
    @(negedge clock);
    chk("strobes", 8'hFF, trialStrobeN);
    chk("code", 8'h00, code);
    @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    conv(16'hC1C1, 7);
    repeat (20) @(negedge clock);
    chk("code", 8'hC1, code);
    chk("strobes", 8'hFF, trialStrobeN);
    results();
  end
endmodule // tb_top
`default_nettype wire
